// ---- rtl/ocl_device.sv ----
// device end: power-up store copy, serial register writes, output drivers
//
// Overview of operation
// R1 - one internal reset pulse on supply good
// R2 - pulse copies every stored value into registers
// R3 - host waits four ms before serial use
// R4 - serial writes blocked when security bit stored; store burn words are still accepted
// R5 - host avoids calibration registers eleven to fourteen
// R6 - host writes reserved bits at defaults
// R7 - fixed 444 bit nonvolatile default store
// R8 - outputs start in stored mode, writable after
// R9 - cmos mode: complementary pin high impedance
// R10 - cmos mode: clock only on true pin
// R11 - reference pair copies reference, mode selectable
// R12 - outputs three, four fed by second loop
// R13 - user programs defaults before relying on them
// R14 - high select level enters store programming
// R15 - serial access ignored while copy runs
`timescale 1ns/1ps
`default_nettype none
module ocl_device
  import ocl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ocl_if.dev spi,
  input wire logic supply_good,
  input wire logic ref_in,
  input wire logic loop1_clk,
  input wire logic second_synth_loop,
  output logic loading,
  output logic locked_cfg,
  output logic [7:0] out_p,
  output logic [7:0] out_oe_n,
  output logic [1:0] reference_copy_out,
  output logic [1:0] reference_copy_oe_n
);
  import ocl_pkg::*;

  // ********************************************************************
  // storage
  // ********************************************************************
  // nonvolatile store, flattened; only programming mode writes it
  logic [OTP_BITS-1:0] otp_mem; // [R7]
  logic [7:0] cfg [CFG_BYTES];
  ocl_state_e state;
  logic [ADDR_W-1:0] ld_idx;

  // pin synchronisers: three stages, change seen when stages 2,3 agree
  logic [2:0] s_sck, s_sdi, s_sel, s_hv, s_pwr;
  logic sck_q, sel_q, hv_q, pwr_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_sck <= 3'h0;
      s_sdi <= 3'h0;
      s_sel <= 3'h7;
      s_hv <= 3'h0;
      s_pwr <= 3'h0;
    end else begin
      s_sck <= {s_sck[1:0], spi.sck};
      s_sdi <= {s_sdi[1:0], spi.sdi};
      s_sel <= {s_sel[1:0], spi.sel_n};
      s_hv <= {s_hv[1:0], spi.prog_hv};
      s_pwr <= {s_pwr[1:0], supply_good};
    end
  end

  // filtered levels update only when the two later stages agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
      hv_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      if (s_sck[1] == s_sck[2]) sck_q <= s_sck[2];
      if (s_sel[1] == s_sel[2]) sel_q <= s_sel[2];
      if (s_hv[1] == s_hv[2]) hv_q <= s_hv[2];
      if (s_pwr[1] == s_pwr[2]) pwr_q <= s_pwr[2];
    end
  end

  // ********************************************************************
  // power-up reset pulse and loader
  // ********************************************************************
  logic pwr_d;
  logic por_pulse;
  assign por_pulse = pwr_q & ~pwr_d; // single rising edge only [R1]

  // store byte k occupies bits 8k+7..8k; tail bits beyond 444 read zero
  function automatic logic [7:0] otp_byte(input logic [ADDR_W-1:0] k);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (int'(k) * 8 + i < OTP_BITS) b[i] = otp_mem[int'(k) * 8 + i];
    end
    return b;
  endfunction

  wire ld_last = (ld_idx == ADDR_W'(CFG_BYTES - 1));
  // read the lock byte directly so a burn is seen at once
  wire [7:0] sec_byte = otp_mem[int'(SEC_ADDR) * 8 +: 8];
  wire sec_set = (sec_byte & SEC_LOCK_MASK) != 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pwr_d <= 1'b0;
    else pwr_d <= pwr_q;
  end

  // one-hot loader; programming mode entered by elevated select level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OCL_ST_OFF;
      ld_idx <= '0;
    end else begin
      case (state)
        OCL_ST_OFF: begin
          if (por_pulse) state <= OCL_ST_LOAD; // [R1]
          ld_idx <= '0;
        end
        OCL_ST_LOAD: begin
          ld_idx <= ld_idx + 1'b1;
          if (ld_last) state <= OCL_ST_RUN;
        end
        OCL_ST_RUN: begin
          if (hv_q) state <= OCL_ST_PROG; // [R14]
        end
        OCL_ST_PROG: begin
          if (!hv_q) state <= OCL_ST_RUN; // [R14]
        end
        default: state <= OCL_ST_OFF;
      endcase
      if (!pwr_q) state <= OCL_ST_OFF;
    end
  end

  // ********************************************************************
  // serial receiver: 16 bits, address[13:8], data[7:0], msb first
  // ********************************************************************
  logic sck_d;
  logic [4:0] bit_cnt;
  logic [15:0] shreg;
  wire sck_rise = sck_q & ~sck_d;
  // only a settled configuration may be changed over the port
  wire spi_live = (state == OCL_ST_RUN) || (state == OCL_ST_PROG); // [R15]
  wire sel_act = ~sel_q & ~hv_q; // normal active-low select [R14]
  wire word_done = sck_rise && (bit_cnt == 5'(SPI_BITS - 1));
  wire [15:0] word = {shreg[14:0], s_sdi[2]};
  wire [ADDR_W-1:0] w_addr = word[8 +: ADDR_W];
  // burn words arrive with select high, so the level qualifies them
  wire w_ok = word_done && (sel_act || hv_q) && spi_live
    && int'(w_addr) < CFG_BYTES;
  // store lock blocks register writes but not a burn cycle
  wire reg_wr = w_ok && sel_act && state == OCL_ST_RUN && !sec_set; // [R4]
  wire otp_wr = w_ok && hv_q && state == OCL_ST_PROG; // [R14]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      bit_cnt <= '0;
      shreg <= '0;
    end else begin
      sck_d <= sck_q;
      if (!(sel_act || hv_q) || !spi_live) bit_cnt <= '0; // [R15]
      else if (sck_rise) begin
        shreg <= word;
        bit_cnt <= word_done ? 5'h0 : bit_cnt + 1'b1;
      end
    end
  end

  // nonvolatile store: burned only in programming mode, one-way bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) otp_mem <= '0;
    else if (otp_wr) begin
      for (int i = 0; i < 8; i++) begin
        if (int'(w_addr) * 8 + i < OTP_BITS && word[i])
          otp_mem[int'(w_addr) * 8 + i] <= 1'b1; // [R13]
      end
    end
  end

  // live registers: loader copy then serial writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CFG_BYTES; i++) cfg[i] <= RSVD_DEFAULT;
    end else if (state == OCL_ST_LOAD) begin
      cfg[ld_idx] <= otp_byte(ld_idx); // [R2]
    end else if (reg_wr) begin
      cfg[w_addr] <= word[7:0]; // [R4]
    end
  end

  // ********************************************************************
  // output drivers
  // ********************************************************************
  // pair i: mode cfg[4][2i+1:2i]; pair 4 (reference) uses cfg[5][1:0]
  wire [1:0] mode_of [5];
  wire [4:0] src_clk;
  assign mode_of[0] = cfg[MODE_ADDR][1:0];
  assign mode_of[1] = cfg[MODE_ADDR][3:2];
  assign mode_of[2] = cfg[MODE_ADDR][5:4];
  assign mode_of[3] = cfg[MODE_ADDR][7:6];
  assign mode_of[4] = cfg[MODE_ADDR + 1'b1][1:0]; // [R11]
  assign src_clk[0] = loop1_clk;
  assign src_clk[1] = loop1_clk;
  assign src_clk[2] = second_synth_loop; // second_synth_loop_clock_out_a [R12]
  assign src_clk[3] = second_synth_loop; // second_synth_loop_clock_out_b [R12]
  assign src_clk[4] = ref_in; // [R11]
  wire run = (state == OCL_ST_RUN);

  // registered pins; held off until the loaded mode is valid [R8]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_p <= 8'h00;
      out_oe_n <= 8'hFF;
      reference_copy_out <= 2'h0;
      reference_copy_oe_n <= 2'h3;
      loading <= 1'b0;
      locked_cfg <= 1'b0;
    end else begin
      loading <= (state == OCL_ST_LOAD);
      locked_cfg <= sec_set;
      for (int i = 0; i < 4; i++) begin
        out_p[2*i] <= src_clk[i]; // true pin [R10]
        out_p[2*i+1] <= ~src_clk[i];
        out_oe_n[2*i] <= ~run;
        out_oe_n[2*i+1] <= ~run || mode_of[i] == OCL_CMOS; // [R9]
      end
      reference_copy_out <= {~src_clk[4], src_clk[4]};
      reference_copy_oe_n <= {~run || mode_of[4] == OCL_CMOS, ~run}; // [R9]
    end
  end
endmodule
`default_nettype wire

// ---- common/ocl_pkg.sv ----
// package: constants and types shared by both ends of the config loader
package ocl_pkg;
  // ********************************************************************
  // store geometry
  // ********************************************************************
  localparam int OTP_BITS = 444;
  localparam int CFG_BYTES = 56;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] SEC_ADDR = 6'h00;
  localparam logic [ADDR_W-1:0] CAL_FIRST = 6'h0B;
  localparam logic [ADDR_W-1:0] CAL_LAST = 6'h0E;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 6'h04;
  localparam logic [ADDR_W-1:0] OE_ADDR = 6'h02;
  localparam logic [7:0] SEC_LOCK_MASK = 8'h80;
  localparam logic [7:0] RSVD_DEFAULT = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_MHZ = 100;
  localparam int SPI_WAIT_MS = 4;
  localparam int SPI_WAIT_CYC = SPI_WAIT_MS * 1000 * 1000 / 10;
  localparam int SPI_BITS = 16;
  localparam int SPI_DIV = 4;
  localparam int POR_FILTER = 3;
  // ********************************************************************
  // output modes and loader states
  // ********************************************************************
  typedef enum logic [1:0] {
    OCL_CMOS = 2'h0,
    OCL_LVDS = 2'h1,
    OCL_PECL = 2'h2,
    OCL_HCSL = 2'h3
  } ocl_mode_e;
  typedef enum logic [3:0] {
    OCL_ST_OFF = 4'h1,
    OCL_ST_LOAD = 4'h2,
    OCL_ST_RUN = 4'h4,
    OCL_ST_PROG = 4'h8
  } ocl_state_e;
endpackage

// ---- common/ocl_if.sv ----
// interface: serial control pins joining host and device
`timescale 1ns/1ps
`default_nettype none
interface ocl_if;
  logic sck;
  logic sdi;
  logic sdo;
  logic sel_n;
  logic prog_hv;
  modport dev (input sck, input sdi, input sel_n, input prog_hv,
    output sdo);
  modport host (output sck, output sdi, output sel_n, output prog_hv,
    input sdo);
endinterface
`default_nettype wire

// ---- rtl/ocl_host.sv ----
// host end: serial writer that waits out the power-up settle time
`timescale 1ns/1ps
`default_nettype none
module ocl_host
  import ocl_pkg::*;
#(
  parameter int WAIT_CYC = SPI_WAIT_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ocl_if.host spi,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic burn_mode,
  output logic wr_busy,
  output logic ready
);
  import ocl_pkg::*;

  // ********************************************************************
  // settle wait and transmitter
  // ********************************************************************
  logic [31:0] wait_cnt;
  logic [15:0] sh;
  logic [4:0] bits;
  logic [1:0] div;
  logic sck_r, sel_r, hv_r, sdi_r;
  wire tick = (div == 2'(SPI_DIV - 1));
  // calibration bytes are refused here so the device never sees them
  wire cal = wr_addr >= CAL_FIRST && wr_addr <= CAL_LAST; // [R5]

  assign spi.sck = sck_r;
  assign spi.sdi = sdi_r;
  assign spi.sel_n = sel_r;
  assign spi.prog_hv = hv_r;

  // no traffic until the settle count runs out [R3]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      wait_cnt <= wait_cnt + 1'b1;
      ready <= (wait_cnt == 32'(WAIT_CYC - 1)); // [R3]
    end
  end

  // one word: sck low half then high half per bit, msb first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '0;
      bits <= '0;
      div <= '0;
      sck_r <= 1'b0;
      sel_r <= 1'b1;
      hv_r <= 1'b0;
      sdi_r <= 1'b0;
      wr_busy <= 1'b0;
    end else if (!wr_busy) begin
      hv_r <= burn_mode; // [R14]
      if (wr_req && ready && !cal) begin // [R3] [R5]
        // unused upper bits sent at their default of zero [R6]
        sh <= {2'h0, wr_addr, wr_data};
        wr_busy <= 1'b1;
        sel_r <= burn_mode; // select stays high in burn mode [R14]
        bits <= '0;
        div <= '0;
      end
    end else begin
      div <= div + 1'b1;
      if (tick) begin
        sck_r <= ~sck_r;
        if (!sck_r) sdi_r <= sh[15];
        else begin
          sh <= {sh[14:0], 1'b0};
          bits <= bits + 1'b1;
          if (bits == 5'(SPI_BITS - 1)) begin
            wr_busy <= 1'b0;
            sel_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ocl_link_asserts.sv ----
// checker: wire-level rules on the serial control link
`timescale 1ns/1ps
`default_nettype none
module ocl_link_asserts
  import ocl_pkg::*;
#(
  parameter int WAIT_CYC = 50
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sel_n,
  input wire logic prog_hv
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  int wait_cnt;
  logic [4:0] bits;
  logic [15:0] shift;
  // bit count spans one selected word only, burn words are skipped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 0;
      bits <= 5'h00;
      shift <= 16'h0000;
    end else begin
      if (wait_cnt < WAIT_CYC) wait_cnt <= wait_cnt + 1;
      if (sel_n) begin
        bits <= 5'h00;
      end else if ($rose(sck)) begin
        bits <= bits + 5'h01;
        shift <= {shift[14:0], sdi};
      end
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence sck_hold_s;
    $stable(sck) [*3];
  endsequence
  settle_wait_a: assert property (wait_cnt < WAIT_CYC |-> sel_n)
    else $error("select taken before settle time");
  sck_rate_a: assert property ($changed(sck) |=> sck_hold_s)
    else $error("serial clock toggles too fast");
  sel_idle_a: assert property (sel_n && !prog_hv |-> !$rose(sck))
    else $error("serial clock rises outside a word");
  word_len_a: assert property ($rose(sel_n) |-> bits == 5'h10)
    else $error("word length is not sixteen bits");
  sdi_hold_a: assert property (!sel_n && sck && $past(sck)
    |-> $stable(sdi))
    else $error("data moved while serial clock high");
  rsvd_zero_a: assert property (!sel_n && $rose(sck) && bits < 5'h02
    |-> !sdi)
    else $error("reserved word bit not zero");
  cal_skip_a: assert property (!sel_n && bits == 5'h08 |->
    !(shift[5:0] inside {[CAL_FIRST:CAL_LAST]}))
    else $error("calibration address sent on the link");
  prog_sel_a: assert property (prog_hv |-> sel_n)
    else $error("select low during programming level");
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: host and device ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ocl_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam int HOST_WAIT = 50; // short settle wait keeps the run brief
  logic ref_clk = 1'b0, rst_n = 1'b0, supply_good = 1'b0, ref_in = 1'b0;
  logic loop1_clk = 1'b0, second_synth_loop = 1'b0, burn_mode = 1'b0;
  logic wr_req = 1'b0;
  logic [5:0] wr_addr = 6'h00;
  logic [7:0] wr_data = 8'h00;
  logic loading, locked_cfg, wr_busy, ready, took;
  logic [7:0] out_p, out_oe_n;
  logic [1:0] reference_copy_out, reference_copy_oe_n;
  int miscompares = 0, checks_done = 0, cycles = 0;
  ocl_if bus();
  assign bus.sdo = 1'b0; // device leaves the return line undriven
  ocl_device ocl_device_inst (.ref_clk, .rst_n, .spi(bus), .supply_good,
    .ref_in, .loop1_clk, .second_synth_loop, .loading, .locked_cfg,
    .out_p, .out_oe_n, .reference_copy_out, .reference_copy_oe_n);
  ocl_host #(.WAIT_CYC(HOST_WAIT)) ocl_host_inst (.ref_clk, .rst_n,
    .spi(bus), .wr_req, .wr_addr, .wr_data, .burn_mode, .wr_busy, .ready);
  ocl_link_asserts #(.WAIT_CYC(HOST_WAIT)) ocl_link_asserts_inst (
    .ref_clk, .rst_n, .sck(bus.sck), .sdi(bus.sdi), .sel_n(bus.sel_n),
    .prog_hv(bus.prog_hv));
  // clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one word; took tells whether the host accepted it
  task automatic spi_write(input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wr_addr <= a;
    wr_data <= d;
    wr_req <= 1'b1;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    #1;
    took = (wr_busy === 1'b1);
    while (wr_busy === 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (12) @(negedge ref_clk); // device update lands after last bit
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // supply rise: one load of store length, then stored modes apply
  task automatic power_up(input logic [7:0] oe_exp, input logic lock_exp);
    int rises, len;
    logic was;
    rises = 0;
    len = 0;
    was = 1'b0;
    @(posedge ref_clk);
    supply_good <= 1'b0;
    repeat (4) @(posedge ref_clk);
    supply_good <= 1'b1;
    repeat (300) begin
      @(negedge ref_clk);
      if (loading === 1'b1 && !was) rises++;
      if (loading === 1'b1) len++;
      was = (loading === 1'b1);
    end
    check(8'(rises), 8'h01);
    check(8'(len), 8'(CFG_BYTES));
    check(out_oe_n, oe_exp);
    check({7'h00, locked_cfg}, {7'h00, lock_exp});
  endtask
  // every drive standard on all pairs and on the reference pair
  task automatic mode_sweep;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      spi_write(MODE_ADDR, {m, m, m, m});
      spi_write(6'h05, {6'h00, m});
      check(out_oe_n, (m == OCL_CMOS) ? 8'hAA : 8'h00);
      check(8'(reference_copy_oe_n), {6'h00, m == OCL_CMOS, 1'b0});
    end
  endtask
  // cmos: true pins follow their own loop, reference copies its input
  task automatic clock_route;
    logic b;
    spi_write(MODE_ADDR, 8'h00);
    spi_write(6'h05, 8'h00);
    for (int i = 0; i < 2; i++) begin
      b = i[0];
      @(posedge ref_clk);
      loop1_clk <= b;
      second_synth_loop <= ~b;
      ref_in <= b;
      repeat (6) @(negedge ref_clk);
      check({4'h0, out_p[6], out_p[4], out_p[2], out_p[0]},
        {4'h0, ~b, ~b, b, b});
      check({7'h00, reference_copy_out[0]}, {7'h00, b});
    end
  endtask
  // calibration refused, then burn lock and lvds defaults, reload
  task automatic lock_and_cal;
    for (int a = 11; a <= 14; a++) begin
      spi_write(6'(a), 8'h5A);
      check({7'h00, took}, 8'h00);
    end
    @(posedge ref_clk);
    burn_mode <= 1'b1;
    spi_write(MODE_ADDR, 8'h55);
    spi_write(SEC_ADDR, SEC_LOCK_MASK);
    @(posedge ref_clk);
    burn_mode <= 1'b0;
    power_up(8'h00, 1'b1);
    spi_write(MODE_ADDR, 8'h00);
    check(out_oe_n, 8'h00);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    check({7'h00, ready}, 8'h00);
    power_up(8'hAA, 1'b0);
    check({7'h00, ready}, 8'h01);
    mode_sweep();
    clock_route();
    lock_and_cal();
    end_of_test();
  end
endmodule
`default_nettype wire
